// ### gpg_consts.vh
`ifndef GPG_CONSTS_VH
`define GPG_CONSTS_VH
// Register word indices; the byte address is four times the index
`define GPG_ADDR_W 12
`define GPG_OFF_DATA 12'h210
`define GPG_OFF_IOEN 12'h212
`define GPG_OFF_PULL 12'h214
`define GPG_OFF_INTF 12'h216
`define GPG_OFF_INTCTL 12'h218
`define GPG_OFF_DEBEN 12'h21A
`define GPG_OFF_MODE 12'h21C
`define GPG_OFF_FUNC 12'h21E
`define GPG_OFF_CLK 12'h2E0
`define GPG_OFF_GRP 12'h2E2
`define GPG_OFF_IRQ_MASK 12'h2E4
// Field positions
`define GPG_HI_LSB 8
`define GPG_FN1_LSB 2
`define GPG_FILTER_CLOCK_DIVIDER_LSB 4
`define GPG_GRP_SECOND 1
// Reset values
`define GPG_RST_IOEN 16'h0003
`define GPG_RST_ZERO 16'h0000
// Function select codes
`define GPG_FN_ALT0 2'h0
`define GPG_FN_ALT1 2'h1
// Debounce: stable samples of the divided filter clock
`define GPG_DEB_SAMPLES 3
`endif

// ### gpg_debounce.v
`default_nettype none
`include "gpg_consts.vh"
module gpg_debounce #(
  parameter SAMPLES = `GPG_DEB_SAMPLES
) (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire din,
  output reg dout
);
  reg [3:0] cnt_r;
  // Accept a new level only after it holds for SAMPLES filter ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= 4'h0;
    end else if (tick) begin
      if (cnt_r == SAMPLES[3:0] - 4'h1) begin
        dout <= din;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### gpg_port.v
`default_nettype none
`include "gpg_consts.vh"
module gpg_port #(
  parameter NPINS = 2
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NPINS-1:0] pin_in,
  output reg [NPINS-1:0] pin_out,
  output reg [NPINS-1:0] pin_oe,
  output reg [NPINS-1:0] pull_up_en,
  output reg [NPINS-1:0] pull_down_en,
  output reg [NPINS-1:0] pin_irq_req,
  input wire buzzer_output,
  input wire one_second_output,
  input wire clock_generator_output,
  input wire internal_fast_oscillator,
  input wire low_frequency_oscillator,
  input wire first_group_pending,
  output reg irq
);
  // Reset image of the packed enable register; inputs off, outputs on
  localparam [15:0] RST_IOEN = `GPG_RST_IOEN;

  // Software-visible register fields
  reg [NPINS-1:0] output_data_bits_r;
  reg [NPINS-1:0] input_enable_bits_r;
  reg [NPINS-1:0] output_enable_bits_r;
  reg [NPINS-1:0] pull_direction_bits_r;
  reg [NPINS-1:0] pull_enable_bits_r;
  reg [NPINS-1:0] pin_interrupt_flags_r;
  reg [NPINS-1:0] edge_select_bits_r;
  reg [NPINS-1:0] pin_interrupt_enables_r;
  reg [NPINS-1:0] debounce_enable_bits_r;
  reg [NPINS-1:0] peripheral_mode_bits_r;
  reg [3:0] function_select_r;
  reg [3:0] filter_clock_divider_r;
  reg filter_clock_source_r;
  reg [1:0] irq_mask_r;

  // Edge history and filter clock state
  reg [NPINS-1:0] prev_in_r;
  reg [15:0] div_cnt_r;
  reg [2:0] src_sync_r;
  reg [15:0] rdata_nxt;

  // Datapath and decode nets
  wire [NPINS-1:0] input_path;
  wire [NPINS-1:0] filtered;
  wire [NPINS-1:0] edge_hit;
  wire [NPINS-1:0] periph_out;
  wire [NPINS-1:0] flag_clear;
  wire [1:0] group_status;
  wire [1:0] irq_cause;
  wire [NPINS-1:0] gpio_pins;
  wire [NPINS-1:0] pull_ok;
  wire [11:0] addr;
  wire wr_acc;
  wire addr_ok;
  wire src_edge;
  wire src_tick;
  wire tick;
  wire [15:0] div_mask;
  genvar g;

  // Word index; every register sits on its own 32-bit word
  assign addr = paddr[13:2];
  // Writes land on the access edge, where ready is also high
  assign wr_acc = psel && penable && pwrite;

  // Known indices; upper address bits and byte lanes must be zero
  assign addr_ok = (paddr[31:14] == 18'h00000) && (paddr[1:0] == 2'b00) &&
    (addr == `GPG_OFF_DATA ||
     addr == `GPG_OFF_IOEN ||
     addr == `GPG_OFF_PULL ||
     addr == `GPG_OFF_INTF ||
     addr == `GPG_OFF_INTCTL ||
     addr == `GPG_OFF_DEBEN ||
     addr == `GPG_OFF_MODE ||
     addr == `GPG_OFF_FUNC ||
     addr == `GPG_OFF_CLK ||
     addr == `GPG_OFF_GRP ||
     addr == `GPG_OFF_IRQ_MASK);

  // Filter clock: slow source is synchronised, its rising edge is one tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sync_r <= 3'b000;
    end else begin
      src_sync_r <= {src_sync_r[1:0], low_frequency_oscillator};
    end
  end
  // Fast source taken as the pclk-domain enable; only stage 2 and 3 are compared
  assign src_edge = src_sync_r[1] & ~src_sync_r[2];
  // Source select: fast enable or one pulse per slow rising edge
  assign src_tick = filter_clock_source_r ? src_edge : internal_fast_oscillator;
  // Low n bits of the divider must be zero for a 1/2^n tick
  assign div_mask = (16'h0001 << filter_clock_divider_r) - 16'h0001;
  // Changing the ratio mid-count may stretch one filter period
  assign tick = src_tick && ((div_cnt_r & div_mask) == 16'h0000);

  // Free divider counting source ticks, ratio 1/2^n
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 16'h0000;
    end else if (src_tick) begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  generate
    for (g = 0; g < NPINS; g = g + 1) begin : pin
      // Input gate first so a disabled input cannot cause edges
      assign input_path[g] = pin_in[g] & input_enable_bits_r[g];
      // Filter always runs, so switching it in cannot glitch
      gpg_debounce u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .din(input_path[g]),
        .dout(filtered[g])
      );
      // Filter inserted or bypassed per pin
      wire cur = debounce_enable_bits_r[g] ? filtered[g] : input_path[g];
      // Falling when select is one, rising otherwise; GPIO mode only
      assign edge_hit[g] = !peripheral_mode_bits_r[g] &&
        (edge_select_bits_r[g] ? (prev_in_r[g] & ~cur) : (~prev_in_r[g] & cur));
      // Write-one-to-clear strobe, only on a mapped access
      assign flag_clear[g] = wr_acc && addr_ok && addr == `GPG_OFF_INTF && pwdata[g];
      // History resets low, the level of a disabled input, so no false edge
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_in_r[g] <= 1'b0;
          pin_interrupt_flags_r[g] <= 1'b0;
        end else begin
          prev_in_r[g] <= cur;
          // Set beats a same-cycle clear so no edge is lost
          if (edge_hit[g]) begin
            pin_interrupt_flags_r[g] <= 1'b1;
          end else if (flag_clear[g]) begin
            pin_interrupt_flags_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Peripheral outputs by function select
  assign periph_out[0] = (function_select_r[1:0] == `GPG_FN_ALT1) ? one_second_output :
    buzzer_output;
  assign periph_out[1] = (function_select_r[3:2] == `GPG_FN_ALT1) ? clock_generator_output :
    ~buzzer_output;

  assign group_status = {|pin_interrupt_flags_r, first_group_pending};
  // Summary bits that may raise the interrupt line
  assign irq_cause = group_status & irq_mask_r;

  // Peripheral mode takes a pin away from every GPIO setting except the interrupt enable, which still passes flags set earlier
  assign gpio_pins = ~peripheral_mode_bits_r;
  // Pulls only on undriven GPIO pins whose pull is enabled
  assign pull_ok = gpio_pins & ~output_enable_bits_r & pull_enable_bits_r;

  // Pads, pulls and requests, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= {NPINS{1'b0}};
      pin_oe <= {NPINS{1'b0}};
      pull_up_en <= {NPINS{1'b0}};
      pull_down_en <= {NPINS{1'b0}};
      pin_irq_req <= {NPINS{1'b0}};
      irq <= 1'b0;
    end else begin
      // Peripheral function always drives; GPIO bits are ignored there
      pin_out <= (peripheral_mode_bits_r & periph_out) |
        (~peripheral_mode_bits_r & output_data_bits_r);
      pin_oe <= peripheral_mode_bits_r | output_enable_bits_r;
      pull_up_en <= pull_ok & pull_direction_bits_r;
      pull_down_en <= pull_ok & ~pull_direction_bits_r;
      pin_irq_req <= pin_interrupt_flags_r & pin_interrupt_enables_r;
      // Interrupt line: any unmasked summary bit
      irq <= |irq_cause;
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_data_bits_r <= {NPINS{1'b0}};
      // Inputs off, outputs driving low after reset
      input_enable_bits_r <= RST_IOEN[`GPG_HI_LSB +: NPINS];
      output_enable_bits_r <= RST_IOEN[NPINS-1:0];
      pull_direction_bits_r <= {NPINS{1'b0}};
      pull_enable_bits_r <= {NPINS{1'b0}};
      edge_select_bits_r <= {NPINS{1'b0}};
      pin_interrupt_enables_r <= {NPINS{1'b0}};
      debounce_enable_bits_r <= {NPINS{1'b0}};
      peripheral_mode_bits_r <= {NPINS{1'b0}};
      function_select_r <= 4'h0;
      filter_clock_divider_r <= 4'h0;
      filter_clock_source_r <= 1'b0;
      irq_mask_r <= 2'b00;
    end else if (wr_acc && addr_ok) begin
      // Flags clear in the pin loop; the summary is read-only
      case (addr)
        // Output data in the high byte; the low byte is status only
        `GPG_OFF_DATA: begin
          output_data_bits_r <= pwdata[`GPG_HI_LSB +: NPINS];
        end
        // Input enables high, output enables low
        `GPG_OFF_IOEN: begin
          input_enable_bits_r <= pwdata[`GPG_HI_LSB +: NPINS];
          output_enable_bits_r <= pwdata[NPINS-1:0];
        end
        // Pull direction high, pull enable low
        `GPG_OFF_PULL: begin
          pull_direction_bits_r <= pwdata[`GPG_HI_LSB +: NPINS];
          pull_enable_bits_r <= pwdata[NPINS-1:0];
        end
        // Edge select high, interrupt enable low
        `GPG_OFF_INTCTL: begin
          edge_select_bits_r <= pwdata[`GPG_HI_LSB +: NPINS];
          pin_interrupt_enables_r <= pwdata[NPINS-1:0];
        end
        // Per-pin filter insertion
        `GPG_OFF_DEBEN: begin
          debounce_enable_bits_r <= pwdata[NPINS-1:0];
        end
        // GPIO or peripheral ownership
        `GPG_OFF_MODE: begin
          peripheral_mode_bits_r <= pwdata[NPINS-1:0];
        end
        // Two select bits per pin
        `GPG_OFF_FUNC: begin
          function_select_r <= pwdata[3:0];
        end
        // Filter clock ratio and source
        `GPG_OFF_CLK: begin
          filter_clock_divider_r <= pwdata[`GPG_FILTER_CLOCK_DIVIDER_LSB +: 4];
          filter_clock_source_r <= pwdata[0];
        end
        // Mask of the summary bits
        `GPG_OFF_IRQ_MASK: begin
          irq_mask_r <= pwdata[1:0];
        end
        // Flag and summary writes change nothing here
        default: begin
          irq_mask_r <= irq_mask_r;
        end
      endcase
    end
  end

  // Read mux; status bits show live state
  always @* begin
    rdata_nxt = 16'h0000;
    // Every index returns a 16-bit image; unused bits stay zero
    case (addr)
      // Output data stored; input status gated by enable and mode
      `GPG_OFF_DATA: begin
        rdata_nxt[`GPG_HI_LSB +: NPINS] = output_data_bits_r;
        rdata_nxt[NPINS-1:0] = input_path & ~peripheral_mode_bits_r;
      end
      // Enables as written
      `GPG_OFF_IOEN: begin
        rdata_nxt[`GPG_HI_LSB +: NPINS] = input_enable_bits_r;
        rdata_nxt[NPINS-1:0] = output_enable_bits_r;
      end
      // Pull settings as written
      `GPG_OFF_PULL: begin
        rdata_nxt[`GPG_HI_LSB +: NPINS] = pull_direction_bits_r;
        rdata_nxt[NPINS-1:0] = pull_enable_bits_r;
      end
      // Live flags
      `GPG_OFF_INTF: rdata_nxt[NPINS-1:0] = pin_interrupt_flags_r;
      // Edge select and interrupt enables
      `GPG_OFF_INTCTL: begin
        rdata_nxt[`GPG_HI_LSB +: NPINS] = edge_select_bits_r;
        rdata_nxt[NPINS-1:0] = pin_interrupt_enables_r;
      end
      // Filter enables
      `GPG_OFF_DEBEN: rdata_nxt[NPINS-1:0] = debounce_enable_bits_r;
      // Pin ownership
      `GPG_OFF_MODE: rdata_nxt[NPINS-1:0] = peripheral_mode_bits_r;
      // Function selects
      `GPG_OFF_FUNC: rdata_nxt[3:0] = function_select_r;
      // Divider in bits 7:4, source in bit 0
      `GPG_OFF_CLK: begin
        rdata_nxt[`GPG_FILTER_CLOCK_DIVIDER_LSB +: 4] = filter_clock_divider_r;
        rdata_nxt[0] = filter_clock_source_r;
      end
      // Group summary, this group in bit 1
      `GPG_OFF_GRP: rdata_nxt[1:0] = group_status;
      // Summary mask
      `GPG_OFF_IRQ_MASK: rdata_nxt[1:0] = irq_mask_r;
      // Unmapped reads return zero
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // APB answer: no wait states, ready pulses in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      // Answer latched from the setup phase for the access edge
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= (!pwrite && addr_ok) ? {16'h0000, rdata_nxt} : 32'h00000000;
    end else begin
      // Read data holds; ready and error drop
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### gpg_port_properties.sv
`default_nettype none
`include "gpg_consts.vh"
module gpg_port_chk #(
  parameter NPINS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pull_up_en,
  input wire logic [NPINS-1:0] pull_down_en,
  input wire logic [NPINS-1:0] pin_irq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Good read completion
  wire logic rd = pready && !pwrite && !pslverr;
  a_apb_answer_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_upper_half_zero: assert property (rd |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_data_unused_zero: assert property (rd && paddr[13:2] == `GPG_OFF_DATA |->
    prdata[15:10] == 6'h00 && prdata[7:2] == 6'h00) else $error("data unused bits set");
  a_pull_off_driven: assert property ((pin_oe & (pull_up_en | pull_down_en)) == 0)
    else $error("pull on driven pin");
  a_pull_one_way: assert property ((pull_up_en & pull_down_en) == 0)
    else $error("both pulls on");
  a_req_shows_flag: assert property (rd && paddr[13:2] == `GPG_OFF_INTF |->
    (pin_irq_req & ~prdata[NPINS-1:0]) == 0) else $error("request without flag");
  a_summary_has_req: assert property (rd && paddr[13:2] == `GPG_OFF_GRP &&
    pin_irq_req != 0 |-> prdata[1]) else $error("summary clear while pending");
  // Main scenarios reached
  cover property (pready && pslverr);
  cover property ($rose(pin_irq_req[0]));
  cover property (pin_oe == 0 && pull_up_en != 0);
endmodule
bind gpg_port gpg_port_chk #(.NPINS(NPINS)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .pin_irq_req(pin_irq_req));
`default_nettype wire

// ### gpg_board.sv
`default_nettype none
module gpg_board (
  input wire logic pclk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pull_up_en,
  input wire logic [1:0] pull_down_en,
  input wire logic [1:0] ext_en,
  input wire logic [1:0] ext_val,
  output logic [1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] float_r = 2'b00;
  // A floating pad wanders, so nothing may lean on a settled level
  always @(posedge pclk) float_r <= ~float_r;
  // Pad level: device drive, then pulls, then board driver
  always_comb for (int i = 0; i < 2; i++)
    pin_in[i] = pin_oe[i] ? pin_out[i] : pull_up_en[i] ? 1'b1 :
      pull_down_en[i] ? 1'b0 : ext_en[i] ? ext_val[i] : float_r[i];
endmodule
`default_nettype wire

// ### gpg_tb.sv
`default_nettype none
`include "gpg_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic buz = 0, sec = 0, cgo = 0, fast = 1, grp0 = 0, slow = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [1:0] pin_in, pin_out, pin_oe, pu, pd, req, ext_en = 0, ext_val = 0;
  logic [32:0] exp_q[$];
  logic [11:0] regs[11] = '{`GPG_OFF_DATA, `GPG_OFF_IOEN, `GPG_OFF_PULL, `GPG_OFF_INTF,
    `GPG_OFF_INTCTL, `GPG_OFF_DEBEN, `GPG_OFF_MODE, `GPG_OFF_FUNC, `GPG_OFF_CLK,
    `GPG_OFF_GRP, `GPG_OFF_IRQ_MASK};
  int miscompares = 0, n_tests = 0, cyc = 0;
  initial forever #5 pclk = ~pclk;
  gpg_port u_gpg_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_en(pu), .pull_down_en(pd), .pin_irq_req(req), .buzzer_output(buz),
    .one_second_output(sec), .clock_generator_output(cgo), .internal_fast_oscillator(fast),
    .low_frequency_oscillator(slow), .first_group_pending(grp0), .irq(irq));
  gpg_board u_gpg_board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
    .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; a read notes its expected {error, data}
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= {18'h0, a, 2'b00};
    pwdata <= {16'($urandom), d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 16'h0, e);
  endtask
  // Pad outputs; drive value only counts where enabled
  task pins(input logic [7:0] e);
    repeat (2) @(negedge pclk);
    chk({pin_oe, pin_out & pin_oe, pu, pd}, e);
    @(posedge pclk);
  endtask
  task hold;
    repeat (5) @(posedge pclk);
  endtask
  // Read checker and hang guard
  always @(posedge pclk) begin
    cyc++;
    // Slow filter source: one rising edge every 8 clocks
    slow <= cyc[2];
    if (cyc > 5000) begin
      miscompares++;
      wrap_up;
    end
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    r = $urandom(18);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) rd(regs[i], (regs[i] == `GPG_OFF_IOEN) ? 33'h3 : 33'h0);
    pins(8'hC0);
    rd(12'h2E8, 33'h100000000);
    wr(`GPG_OFF_GRP, 16'hFFFF);
    rd(`GPG_OFF_GRP, 33'h0);
    wr(`GPG_OFF_DATA, 16'h0200);
    pins(8'hE0);
    wr(`GPG_OFF_IOEN, 16'h0300);
    wr(`GPG_OFF_PULL, 16'h0203);
    wr(`GPG_OFF_DATA, 16'h0100);
    pins(8'h09);
    rd(`GPG_OFF_DATA, 33'h0102);
    wr(`GPG_OFF_IOEN, 16'h0303);
    pins(8'hD0);
    rd(`GPG_OFF_DATA, 33'h0101);
    wr(`GPG_OFF_IOEN, 16'h0003);
    rd(`GPG_OFF_DATA, 33'h0100);
    ext_en <= 2'b11;
    ext_val <= 2'b10;
    wr(`GPG_OFF_IOEN, 16'h0300);
    wr(`GPG_OFF_PULL, 16'h0000);
    wr(`GPG_OFF_INTF, 16'h0003);
    wr(`GPG_OFF_INTCTL, 16'h0203);
    wr(`GPG_OFF_IRQ_MASK, 16'h0002);
    ext_val <= 2'b11;
    hold;
    rd(`GPG_OFF_INTF, 33'h0001);
    rd(`GPG_OFF_GRP, 33'h0002);
    chk({irq, req}, 3'b101);
    ext_val <= 2'b01;
    hold;
    ext_val <= 2'b00;
    hold;
    rd(`GPG_OFF_INTF, 33'h0003);
    wr(`GPG_OFF_INTF, 16'h0001);
    wr(`GPG_OFF_INTF, 16'h0000);
    rd(`GPG_OFF_INTF, 33'h0002);
    wr(`GPG_OFF_INTF, 16'h0002);
    rd(`GPG_OFF_GRP, 33'h0);
    chk(irq, 1'b0);
    grp0 <= 1;
    wr(`GPG_OFF_IRQ_MASK, 16'h0001);
    rd(`GPG_OFF_GRP, 33'h0001);
    chk(irq, 1'b1);
    grp0 <= 0;
    wr(`GPG_OFF_MODE, 16'h0003);
    wr(`GPG_OFF_PULL, 16'h0303);
    wr(`GPG_OFF_INTF, 16'h0003);
    for (int f = 0; f < 2; f++) begin
      wr(`GPG_OFF_FUNC, f ? 16'h0005 : 16'h0000);
      repeat (3) begin
        r = $urandom;
        {buz, sec, cgo} <= r[2:0];
        pins(f ? {2'b11, r[0], r[1], 4'h0} : {2'b11, ~r[2], r[2], 4'h0});
      end
    end
    rd(`GPG_OFF_DATA, 33'h0100);
    rd(`GPG_OFF_INTF, 33'h0);
    wr(`GPG_OFF_MODE, 16'h0000);
    wr(`GPG_OFF_PULL, 16'h0000);
    wr(`GPG_OFF_INTF, 16'h0003);
    wr(`GPG_OFF_DEBEN, 16'h0001);
    ext_val <= 2'b01;
    @(posedge pclk);
    ext_val <= 2'b00;
    hold;
    rd(`GPG_OFF_INTF, 33'h0);
    ext_val <= 2'b01;
    repeat (3) hold;
    rd(`GPG_OFF_INTF, 33'h0001);
    // Slow source, ratio 1/2: three ticks take over thirty clocks
    wr(`GPG_OFF_CLK, 16'h0011);
    rd(`GPG_OFF_CLK, 33'h0011);
    ext_val <= 2'b00;
    repeat (12) hold;
    wr(`GPG_OFF_INTF, 16'h0003);
    ext_val <= 2'b01;
    hold;
    rd(`GPG_OFF_INTF, 33'h0);
    repeat (12) hold;
    rd(`GPG_OFF_INTF, 33'h0001);
    wrap_up;
  end
endmodule
`default_nettype wire
